// >>> rtl/safety_seq_consts.svh
// Constants for the safety test judgment sequencer: register map, fields, timing.
// Assumes a 20 MHz system clock and an AHB-Lite register bus with 32-bit data.
`ifndef SAFETY_SEQ_CONSTS_SVH
`define SAFETY_SEQ_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CONTROL      8'h00
`define OFS_ARC_LIMIT    8'h04
`define OFS_PASS_HOLD    8'h08
`define OFS_TEST_TIME    8'h0C
`define OFS_CONTACT      8'h10
`define OFS_STATUS       8'h14
`define OFS_RESULT       8'h18
`define OFS_OFFSET       8'h1C

// ****************************************
// Control register fields
// ****************************************
`define CTL_FUNC_LSB     0
`define CTL_ARC_LSB      2
`define CTL_SPEED_LSB    4
`define CTL_STOPM_LSB    6
`define CTL_MAXHOLD_BIT  8
`define CTL_HOLDINF_BIT  9
`define CTL_AUTO_BIT     10
`define CTL_OFFSET_BIT   11
`define CTL_VARIANT_BIT  12
`define CTL_WIDTH        13

// ****************************************
// Limits in 1 uA steps, durations in 0.1 s ticks
// ****************************************
`define ARC_MIN_UA       20'h003E8
`define ARC_ACW_LO_UA    20'h13880
`define ARC_ACW_HI_UA    20'h30D40
`define ARC_DCW_LO_UA    20'h04E20
`define ARC_DCW_HI_UA    20'h09C40
`define TIME_MAX_TICKS   14'h270F
`define EARLY_TICKS      14'h0003

// ****************************************
// Timing
// ****************************************
`define CLK_HZ           20000000
`define TICK_MS          100
`define TICK_CYCLES      ((`CLK_HZ / 1000) * `TICK_MS)
`define ARC_FAST_CYC     8'h02
`define ARC_NORM_CYC     8'h0A
`define ARC_SLOW_CYC     8'h28

`endif

// >>> rtl/safety_seq_pkg.sv
// Types for the safety test judgment sequencer.
// Assumes the constants header is included by the design files.
package safety_seq_pkg;
  typedef enum logic [1:0] {FN_ACW, FN_DCW, FN_IR, FN_GB} test_func_t;
  typedef enum logic [1:0] {ARC_OFF, ARC_CONT, ARC_STOP, ARC_RSVD} arc_mode_t;
  typedef enum logic [1:0] {SPD_FAST, SPD_NORMAL, SPD_SLOW, SPD_RSVD} arc_speed_t;
  typedef enum logic [1:0] {IRM_STOP_FAIL, IRM_STOP_PASS, IRM_TIMER, IRM_RSVD} stop_mode_t;
  typedef enum {ST_IDLE, ST_CONTACT, ST_TEST, ST_OFFSET, ST_PASS_HOLD, ST_DONE} seq_state_t;
endpackage : safety_seq_pkg

// >>> rtl/arc_width_filter.sv
// Arc width qualifier: flags an arc when the over-threshold run reaches the speed width.
// Assumes arc_over is synchronous to clk and already compares current against the limit.
`include "safety_seq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module arc_width_filter (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      clk_en,
  // Arc input
  input  wire logic                      enable,
  input  wire logic                      arc_over,
  input  wire safety_seq_pkg::arc_speed_t speed,
  // Qualified arc
  output logic                           arc_hit
);
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  wire  [7:0] width_need;

  // Fast catches the narrowest spike, slow tolerates the widest
  assign width_need = (speed == safety_seq_pkg::SPD_FAST) ? `ARC_FAST_CYC :
                      (speed == safety_seq_pkg::SPD_SLOW) ? `ARC_SLOW_CYC :
                                                            `ARC_NORM_CYC;
  assign run_nxt    = (!enable || !arc_over) ? 8'h00 :
                      (run_r == width_need)   ? run_r : run_r + 8'h01;
  assign arc_hit    = enable && (run_r == width_need);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      run_r <= 8'h00;
    else if (clk_en)
      run_r <= run_nxt;
  end
endmodule : arc_width_filter
`default_nettype wire

// >>> rtl/safety_seq.sv
// Test sequencing and PASS/FAIL judgment for a high-voltage safety tester.
// Assumes AHB-Lite registers, measurements synchronous to a 20 MHz clk.
// How it works
// - Arc mode is off, continue or stop.
// - Continue mode records arcs, test runs on.
// - Stop mode ends the test on arc.
// - Arc detection only in AC/DC withstand.
// - Arc limit writable only while arc enabled.
// - AC arc limit 1 to 80 or 200 mA.
// - DC arc limit 1 to 20 or 40 mA.
// - Arc width: fast, normal or slow.
// - Max hold reports largest current or resistance.
// - Held maximum replaced only by larger value.
// - PASS held for programmed hold time.
// - Stop key ends pass hold at once.
// - Indefinite hold keeps PASS until stop.
// - Pass hold ignored in automatic sequence.
// - Insulation stop-on-fail judges FAIL from 0.3 s.
// - Insulation stop-on-pass judges PASS from 0.3 s.
// - Insulation timer mode runs full test time.
// - Short circuit fails immediately, even timer mode.
// - Stop modes apply to insulation tests only.
// - Offset run with leads removed stores offset.
// - Ground bond counts contact delay, then test.
`include "safety_seq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// Tick length in clocks; a bench may shorten it to reach timed verdicts
module safety_seq #(parameter int TICK_LEN = `TICK_CYCLES) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Front panel keys
  input  wire logic        start_key,
  input  wire logic        stop_key,
  // Analog front end
  input  wire logic [19:0] meas_value,
  input  wire logic        meas_valid,
  input  wire logic        meas_fail,
  input  wire logic        meas_short,
  input  wire logic [19:0] arc_current,
  // Judgment outputs
  output logic             test_active,
  output logic             pass_ind,
  output logic             fail_ind,
  output logic             arc_seen,
  output logic [19:0]      shown_value
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [`CTL_WIDTH-1:0]    ctl_r;
  logic [19:0]              arc_lim_r;
  logic [13:0]              hold_set_r;
  logic [13:0]              time_set_r;
  logic [13:0]              contact_set_r;
  logic [19:0]              offset_r;
  logic [19:0]              shown_r;
  logic                     pass_r;
  logic                     fail_r;
  logic                     arc_r;
  logic [13:0]              ticks_r;
  logic [21:0]              div_r;
  safety_seq_pkg::seq_state_t state_r;
  safety_seq_pkg::seq_state_t state_nxt;
  logic                     ph_we_r;
  logic [7:0]               ph_addr_r;

  // ****************************************
  // Configuration decode
  // ****************************************
  wire safety_seq_pkg::test_func_t func  =
    safety_seq_pkg::test_func_t'(ctl_r[`CTL_FUNC_LSB +: 2]);
  wire safety_seq_pkg::arc_mode_t  arcm  =
    safety_seq_pkg::arc_mode_t'(ctl_r[`CTL_ARC_LSB +: 2]);
  wire safety_seq_pkg::arc_speed_t speed =
    safety_seq_pkg::arc_speed_t'(ctl_r[`CTL_SPEED_LSB +: 2]);
  wire safety_seq_pkg::stop_mode_t stopm =
    safety_seq_pkg::stop_mode_t'(ctl_r[`CTL_STOPM_LSB +: 2]);
  wire max_hold  = ctl_r[`CTL_MAXHOLD_BIT];
  wire hold_inf  = ctl_r[`CTL_HOLDINF_BIT];
  wire auto_seq  = ctl_r[`CTL_AUTO_BIT];
  wire offset_en = ctl_r[`CTL_OFFSET_BIT];
  wire hi_power  = ctl_r[`CTL_VARIANT_BIT];

  wire withstand = (func == safety_seq_pkg::FN_ACW) || (func == safety_seq_pkg::FN_DCW);
  wire is_ir     = (func == safety_seq_pkg::FN_IR);
  wire arc_on    = withstand && (arcm == safety_seq_pkg::ARC_CONT ||
                                 arcm == safety_seq_pkg::ARC_STOP);

  // Arc limit bounds per function and power variant
  wire [19:0] arc_max = (func == safety_seq_pkg::FN_ACW) ?
                        (hi_power ? `ARC_ACW_HI_UA : `ARC_ACW_LO_UA) :
                        (hi_power ? `ARC_DCW_HI_UA : `ARC_DCW_LO_UA);

  // ****************************************
  // Tick base
  // ****************************************
  wire tick = (div_r == 22'(TICK_LEN - 1));

  // ****************************************
  // Arc qualification
  // ****************************************
  wire arc_hit;
  arc_width_filter arc_width_filter_inst (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .enable   (arc_on && state_r == safety_seq_pkg::ST_TEST),
    .arc_over (arc_current > arc_lim_r),
    .speed    (speed),
    .arc_hit  (arc_hit)
  );

  // ****************************************
  // Judgment decode
  // ****************************************
  wire in_test    = (state_r == safety_seq_pkg::ST_TEST);
  wire time_up    = (ticks_r >= time_set_r); // Whole ticks elapsed, not one extra
  wire early_ok   = is_ir && (ticks_r >= `EARLY_TICKS);
  wire fail_early = meas_valid && meas_fail && (!is_ir || stopm == safety_seq_pkg::IRM_STOP_FAIL)
                    && (!is_ir || early_ok);
  wire pass_early = early_ok && meas_valid && !meas_fail &&
                    (stopm == safety_seq_pkg::IRM_STOP_PASS);
  wire arc_stop   = arc_hit && (arcm == safety_seq_pkg::ARC_STOP);
  wire short_fail = in_test && meas_short;
  wire do_fail    = in_test && (fail_early || arc_stop || short_fail ||
                                (time_up && meas_fail));
  wire do_pass    = in_test && !do_fail && (pass_early || (time_up && !meas_fail));
  wire hold_used  = !auto_seq && (hold_inf || hold_set_r != 14'h0000);
  wire hold_end   = stop_key || (!hold_inf && ticks_r >= hold_set_r);
  wire larger     = meas_valid && (meas_value > shown_r);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      safety_seq_pkg::ST_IDLE, safety_seq_pkg::ST_DONE: begin
        if (start_key && is_ir && offset_en)
          state_nxt = safety_seq_pkg::ST_OFFSET;
        else if (start_key && func == safety_seq_pkg::FN_GB)
          state_nxt = safety_seq_pkg::ST_CONTACT;
        else if (start_key)
          state_nxt = safety_seq_pkg::ST_TEST;
      end
      safety_seq_pkg::ST_CONTACT: begin
        if (stop_key)
          state_nxt = safety_seq_pkg::ST_DONE;
        else if (ticks_r >= contact_set_r)
          state_nxt = safety_seq_pkg::ST_TEST;
      end
      safety_seq_pkg::ST_TEST: begin
        if (stop_key || do_fail)
          state_nxt = safety_seq_pkg::ST_DONE;
        else if (do_pass)
          state_nxt = hold_used ? safety_seq_pkg::ST_PASS_HOLD : safety_seq_pkg::ST_DONE;
      end
      safety_seq_pkg::ST_OFFSET: begin
        if (meas_valid || stop_key)
          state_nxt = safety_seq_pkg::ST_DONE;
      end
      safety_seq_pkg::ST_PASS_HOLD: begin
        if (hold_end)
          state_nxt = safety_seq_pkg::ST_DONE;
      end
      default: state_nxt = safety_seq_pkg::ST_IDLE;
    endcase
  end

  wire state_chg = (state_nxt != state_r);
  wire starting  = state_chg && (state_r == safety_seq_pkg::ST_IDLE ||
                                 state_r == safety_seq_pkg::ST_DONE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= safety_seq_pkg::ST_IDLE;
      div_r   <= 22'h000000;
      ticks_r <= 14'h0000;
    end else if (clk_en) begin
      state_r <= state_nxt;
      div_r   <= (state_chg || tick) ? 22'h000000 : div_r + 22'h000001;
      if (state_chg)
        ticks_r <= 14'h0000;
      else if (tick && ticks_r != `TIME_MAX_TICKS)
        ticks_r <= ticks_r + 14'h0001;
    end
  end

  // ****************************************
  // Verdicts, arc flag, displayed value
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pass_r  <= 1'b0;
      fail_r  <= 1'b0;
      arc_r   <= 1'b0;
      shown_r <= 20'h00000;
    end else if (clk_en) begin
      if (starting) begin
        pass_r  <= 1'b0;
        fail_r  <= 1'b0;
        arc_r   <= 1'b0;
        shown_r <= 20'h00000;
      end else begin
        if (do_fail)
          fail_r <= 1'b1;
        if (do_pass)
          pass_r <= 1'b1;
        else if (state_r == safety_seq_pkg::ST_PASS_HOLD && hold_end)
          pass_r <= 1'b0;
        if (arc_hit)
          arc_r <= 1'b1;
        if (in_test && (max_hold ? larger : meas_valid))
          shown_r <= meas_value;
      end
    end
  end

  // Offset captured from the lead-free measurement
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      offset_r <= 20'h00000;
    else if (clk_en && state_r == safety_seq_pkg::ST_OFFSET && meas_valid)
      offset_r <= meas_value;
  end

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  wire take  = hsel && hready && htrans[1];
  wire wr_ok = ph_we_r && clk_en;
  wire [19:0] arc_wdata = hwdata[19:0];
  wire arc_wr_ok = arc_on && (arc_wdata >= `ARC_MIN_UA) && (arc_wdata <= arc_max);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_we_r   <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (clk_en) begin
      ph_we_r   <= take && hwrite;
      ph_addr_r <= haddr;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r         <= '0;
      arc_lim_r     <= `ARC_MIN_UA;
      hold_set_r    <= 14'h0000;
      time_set_r    <= 14'h000A;
      contact_set_r <= 14'h0000;
    end else if (wr_ok) begin
      case (ph_addr_r)
        `OFS_CONTROL:   ctl_r         <= hwdata[`CTL_WIDTH-1:0];
        `OFS_ARC_LIMIT: if (arc_wr_ok) arc_lim_r <= arc_wdata;
        `OFS_PASS_HOLD: hold_set_r    <= (hwdata[13:0] > `TIME_MAX_TICKS) ?
                                         `TIME_MAX_TICKS : hwdata[13:0];
        `OFS_TEST_TIME: time_set_r    <= (hwdata[13:0] > `TIME_MAX_TICKS) ?
                                         `TIME_MAX_TICKS : hwdata[13:0];
        `OFS_CONTACT:   contact_set_r <= (hwdata[13:0] > `TIME_MAX_TICKS) ?
                                         `TIME_MAX_TICKS : hwdata[13:0];
        default: ;
      endcase
    end
  end

  // Read data is combinational from the address-phase register
  always_comb begin
    case (ph_addr_r)
      `OFS_CONTROL:   hrdata = {19'h00000, ctl_r};
      `OFS_ARC_LIMIT: hrdata = {12'h000, arc_lim_r};
      `OFS_PASS_HOLD: hrdata = {18'h00000, hold_set_r};
      `OFS_TEST_TIME: hrdata = {18'h00000, time_set_r};
      `OFS_CONTACT:   hrdata = {18'h00000, contact_set_r};
      `OFS_STATUS:    hrdata = {11'h000, 3'(state_r), ticks_r, arc_r, fail_r, pass_r,
                                test_active};
      `OFS_RESULT:    hrdata = {12'h000, shown_r};
      `OFS_OFFSET:    hrdata = {12'h000, offset_r};
      default:        hrdata = 32'h00000000;
    endcase
  end

  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign test_active = (state_r == safety_seq_pkg::ST_CONTACT) || in_test ||
                       (state_r == safety_seq_pkg::ST_OFFSET);
  assign pass_ind    = pass_r;
  assign fail_ind    = fail_r;
  assign arc_seen    = arc_r;
  assign shown_value = shown_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_arc_stop;
    in_test && arc_hit && arcm == safety_seq_pkg::ARC_STOP && clk_en;
  endsequence
  sequence s_in_hold;
    state_r == safety_seq_pkg::ST_PASS_HOLD && clk_en;
  endsequence

  AST_ARC_STOP: assert property (@(posedge clk) disable iff (!reset_n)
    s_arc_stop |=> (fail_r && state_r == safety_seq_pkg::ST_DONE))
    else $error("arc in stop mode did not end test");
  AST_ARC_CONT: assert property (@(posedge clk) disable iff (!reset_n)
    (in_test && arc_hit && arcm == safety_seq_pkg::ARC_CONT && !do_fail && !do_pass
     && !stop_key && clk_en) |=> (in_test && arc_r))
    else $error("arc in continue mode stopped test");
  AST_ARC_DETECT_MODE: assert property (@(posedge clk) disable iff (!reset_n)
    (in_test && !withstand && clk_en) |=> $stable(arc_r))
    else $error("arc flagged outside withstand test");
  AST_ARC_LOCK: assert property (@(posedge clk) disable iff (!reset_n)
    (!arc_on && clk_en) |=> $stable(arc_lim_r))
    else $error("arc limit changed while arc disabled");
  AST_MAX_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (in_test && max_hold && !starting && clk_en) |=> shown_r >= $past(shown_r))
    else $error("held maximum decreased");
  AST_HOLD_STOP: assert property (@(posedge clk) disable iff (!reset_n)
    (s_in_hold and stop_key) |=> (!pass_r && state_r == safety_seq_pkg::ST_DONE))
    else $error("stop key did not end pass hold");
  AST_HOLD_INF: assert property (@(posedge clk) disable iff (!reset_n)
    (s_in_hold and (hold_inf && !stop_key)) |=> pass_r)
    else $error("indefinite pass hold dropped early");
  AST_AUTO_NOHOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (auto_seq && in_test && do_pass && clk_en) |=> state_r == safety_seq_pkg::ST_DONE)
    else $error("pass hold used in automatic sequence");
  AST_SHORT: assert property (@(posedge clk) disable iff (!reset_n)
    (in_test && meas_short && clk_en) |=> fail_r)
    else $error("short circuit did not fail");
  AST_TIMER: assert property (@(posedge clk) disable iff (!reset_n)
    (in_test && is_ir && stopm == safety_seq_pkg::IRM_TIMER && !meas_short && !stop_key
     && !time_up && clk_en) |=> (!pass_r && !fail_r))
    else $error("timer mode judged before test time");
  AST_BOND_CONTACT_DELAY: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == safety_seq_pkg::ST_CONTACT) |-> !pass_r && !fail_r)
    else $error("verdict during contact delay");
endmodule : safety_seq
`default_nettype wire

// >>> verif/front_end_model.sv
// Behavioural model of the analog front end that feeds the sequencer.
// Assumes the bench steers it with level commands changed after rising edges.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Bench commands
  input  wire logic [19:0] set_value,
  input  wire logic [3:0]  set_gap,
  input  wire logic        set_fail,
  input  wire logic        set_short,
  input  wire logic [19:0] set_arc,
  // Measurement outputs
  output logic [19:0]      meas_value,
  output logic             meas_valid,
  output logic             meas_fail,
  output logic             meas_short,
  output logic [19:0]      arc_current
);
  // ****************************************
  // Sample pacing
  // ****************************************
  logic [3:0] gap_r;
  // Between samples the value toggles, so unqualified use shows up at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_r       <= 4'h0;
      meas_valid  <= 1'b0;
      meas_value  <= 20'h00000;
      meas_fail   <= 1'b0;
      meas_short  <= 1'b0;
      arc_current <= 20'h00000;
    end else begin
      meas_valid  <= (gap_r == set_gap);
      gap_r       <= (gap_r == set_gap) ? 4'h0 : gap_r + 4'h1;
      meas_value  <= (gap_r == set_gap) ? set_value : ~meas_value;
      meas_fail   <= set_fail;
      meas_short  <= set_short;
      arc_current <= set_arc;
    end
  end
endmodule : front_end_model
`default_nettype wire

// >>> verif/test_safety_seq.sv
// Self-checking bench: AHB-Lite register tasks and judgment scenarios.
// Assumes the design files and the front end model are compiled first.
`include "safety_seq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_safety_seq;
  logic        clk, reset_n, hsel, hwrite, hrdy, hresp, start_key, stop_key, clk_en;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic [19:0] meas_value, arc_current, shown_value, set_value, set_arc;
  logic        meas_valid, meas_fail, meas_short, set_fail, set_short;
  logic        test_active, pass_ind, fail_ind, arc_seen;
  logic [3:0]  set_gap;
  int          n_mismatch = 0;
  int          comparisons = 0;
  localparam int TK = 40;
  logic [31:0] lv [10] = '{32'h3E8, 32'h13880, 32'h13881, 32'h3E7, 32'h30D40,
                           32'h30D41, 32'h4E20, 32'h4E21, 32'h9C40, 32'h9C41};
  logic [31:0] le [10] = '{32'h3E8, 32'h13880, 32'h13880, 32'h13880, 32'h30D40,
                           32'h30D40, 32'h4E20, 32'h4E20, 32'h9C40, 32'h9C40};
  logic [1:0]  lm [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h3};
  // Pulse widths straddle the normal and slow qualifying runs and exceed the fast one
  logic [1:0]  sp [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  int          pw [5] = '{5, 5, 20, 20, 60};
  logic        pe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  safety_seq #(.TICK_LEN(TK)) safety_seq_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .start_key(start_key), .stop_key(stop_key), .meas_value(meas_value),
    .meas_valid(meas_valid), .meas_fail(meas_fail), .meas_short(meas_short),
    .arc_current(arc_current), .test_active(test_active), .pass_ind(pass_ind),
    .fail_ind(fail_ind), .arc_seen(arc_seen), .shown_value(shown_value));
  front_end_model front_end_model_inst (.clk(clk), .reset_n(reset_n),
    .set_value(set_value), .set_gap(set_gap), .set_fail(set_fail), .set_short(set_short),
    .set_arc(set_arc), .meas_value(meas_value), .meas_valid(meas_valid),
    .meas_fail(meas_fail), .meas_short(meas_short), .arc_current(arc_current));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(q & m, e);
  endtask : rdchk
  task automatic key(input logic s);
    @(posedge clk);
    if (s) start_key <= 1'b1; else stop_key <= 1'b1;
    @(posedge clk);
    start_key <= 1'b0;
    stop_key  <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : key
  task automatic arc_pulse(input int n);
    set_arc <= 20'h01770;
    repeat (n) @(posedge clk);
    set_arc <= 20'h00000;
    repeat (4) @(posedge clk);
  endtask : arc_pulse
  task automatic hold_value(input logic [19:0] v);
    set_value <= v;
    repeat (10) @(posedge clk);
  endtask : hold_value
  function automatic logic [31:0] ctl(input logic [1:0] f, input logic [1:0] a,
      input logic [1:0] s, input logic [1:0] m, input logic [4:0] b);
    ctl = {19'h0, b, m, s, a, f};
  endfunction : ctl

  // ****************************************
  // Clock, watchdog and scenarios
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {reset_n, hsel, hwrite, start_key, stop_key, set_fail, set_short} = 7'h00;
    clk_en = 1'b1;
    {haddr, htrans, hsize, hwdata} = 45'h0;
    {set_value, set_arc, set_gap} = 44'h1;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(`OFS_CONTROL, 32'h0);
    rdchk(`OFS_ARC_LIMIT, 32'h3E8);
    rdchk(`OFS_TEST_TIME, 32'hA);
    rdchk(8'h20, 32'h0);
    wr(`OFS_ARC_LIMIT, 32'h1388);
    rdchk(`OFS_ARC_LIMIT, 32'h3E8);
    for (int i = 0; i < 10; i++) begin
      wr(`OFS_CONTROL, ctl({1'b0, lm[i][0]}, 2'h1, 2'h0, 2'h0, {lm[i][1], 4'h0}));
      wr(`OFS_ARC_LIMIT, lv[i]);
      rdchk(`OFS_ARC_LIMIT, le[i]);
    end
    wr(`OFS_CONTROL, ctl(2'h0, 2'h1, 2'h0, 2'h0, 5'h00));
    wr(`OFS_ARC_LIMIT, 32'h1388);
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_CONTROL, ctl(2'h0, 2'h1, sp[i], 2'h0, 5'h00));
      key(1'b1);
      arc_pulse(pw[i]);
      check({31'h0, arc_seen}, {31'h0, pe[i]});
      check({31'h0, test_active}, 32'h1);
      key(1'b0);
    end
    wr(`OFS_CONTROL, ctl(2'h0, 2'h2, 2'h0, 2'h0, 5'h00));
    key(1'b1);
    arc_pulse(60);
    check({30'h0, fail_ind, test_active}, 32'h2);
    wr(`OFS_CONTROL, ctl(2'h2, 2'h2, 2'h0, 2'h2, 5'h00));
    key(1'b1);
    arc_pulse(60);
    check({29'h0, arc_seen, fail_ind, test_active}, 32'h1);
    set_short <= 1'b1;
    repeat (4) @(posedge clk);
    check({30'h0, fail_ind, test_active}, 32'h2);
    set_short <= 1'b0;
    set_fail  <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_CONTROL, ctl(2'h2, 2'h0, 2'h0, i ? 2'h2 : 2'h0, 5'h00));
      key(1'b1);
      repeat (TK * 2) @(posedge clk);
      check({30'h0, fail_ind, test_active}, 32'h1);
      repeat (TK * 2) @(posedge clk);
      check({30'h0, fail_ind, test_active}, i ? 32'h1 : 32'h2);
      repeat (TK * 7) @(posedge clk);
      check({30'h0, fail_ind, test_active}, 32'h2);
      key(1'b0);
    end
    wr(`OFS_CONTROL, ctl(2'h0, 2'h0, 2'h0, 2'h0, 5'h00));
    key(1'b1);
    repeat (4) @(posedge clk);
    check({30'h0, fail_ind, test_active}, 32'h2);
    set_fail <= 1'b0;
    set_gap  <= 4'h2;
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_CONTROL, ctl(2'h0, 2'h0, 2'h0, 2'h0, {4'h0, i == 0}));
      key(1'b1);
      hold_value(20'h0012C);
      hold_value(20'h00064);
      check({12'h0, shown_value}, i ? 32'h64 : 32'h12C);
      hold_value(20'h00190);
      check({12'h0, shown_value}, 32'h190);
      key(1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_CONTROL, ctl(2'h2, 2'h0, 2'h0, i ? 2'h2 : 2'h1, 5'h00));
      key(1'b1);
      repeat (TK * 2) @(posedge clk);
      check({29'h0, pass_ind, fail_ind, test_active}, 32'h1);
      repeat (TK * (i ? 9 : 2)) @(posedge clk);
      check({29'h0, pass_ind, fail_ind, test_active}, 32'h4);
      key(1'b0);
    end
    wr(`OFS_PASS_HOLD, 32'h5);
    wr(`OFS_CONTROL, ctl(2'h2, 2'h0, 2'h0, 2'h1, 5'h00));
    key(1'b1);
    repeat (TK * 4) @(posedge clk);
    check({31'h0, pass_ind}, 32'h1);
    repeat (TK * 5) @(posedge clk);
    check({31'h0, pass_ind}, 32'h0);
    wr(`OFS_CONTROL, ctl(2'h2, 2'h0, 2'h0, 2'h1, 5'h02));
    key(1'b1);
    repeat (TK * 12) @(posedge clk);
    rdchk(`OFS_STATUS, 32'h00100002, 32'h001C0002);
    key(1'b0);
    check({31'h0, pass_ind}, 32'h0);
    wr(`OFS_CONTROL, ctl(2'h2, 2'h0, 2'h0, 2'h1, 5'h04));
    key(1'b1);
    repeat (TK * 4) @(posedge clk);
    rdchk(`OFS_STATUS, 32'h00140002, 32'h001C0002);
    wr(`OFS_CONTACT, 32'h5);
    wr(`OFS_CONTROL, ctl(2'h3, 2'h0, 2'h0, 2'h0, 5'h00));
    key(1'b1);
    rdchk(`OFS_STATUS, 32'h00040001, 32'h001C0001);
    clk_en <= 1'b0;
    repeat (TK * 6) @(posedge clk);
    clk_en <= 1'b1;
    rdchk(`OFS_STATUS, 32'h00040001, 32'h001C0001);
    repeat (TK * 5) @(posedge clk);
    rdchk(`OFS_STATUS, 32'h00080001, 32'h001C0001);
    key(1'b0);
    set_value <= 20'h00123;
    wr(`OFS_CONTROL, ctl(2'h2, 2'h0, 2'h0, 2'h2, 5'h08));
    key(1'b1);
    repeat (10) @(posedge clk);
    rdchk(`OFS_OFFSET, 32'h123);
    key(1'b0);
    summarize();
  end
endmodule : test_safety_seq
`default_nettype wire
